/* File: rtl/pisos_defs.vh */
// Constants for the eight-stage parallel-load serial-out shifter
// What this block does
// - Low shift_not_load loads parallel inputs into stages
// - Load is transparent while shift_not_load stays low
// - During load serial output equals last input
// - No qualifying edge: stages hold their value
// - Qualifying edge shifts; serial input enters first
// - Last stage value is dropped on shift
// - Outputs show last stage and its complement
// - High clock_inhibit blocks clock edges; its own rising edge shifts only while clock is low
// - Clock and clock_inhibit are interchangeable edge sources
// - Data moves toward the serial output end
// - Stages have no reset, start unknown
// - Exactly eight one-bit stages, eight parallel inputs
`ifndef PISOS_DEFS_VH
`define PISOS_DEFS_VH

// =====================================================
// Shift chain
`define PISOS_STAGES 8
`define PISOS_LAST 7

// =====================================================
// Output FIFO
`define PISOS_FIFO_WIDTH 1
`define PISOS_FIFO_DEPTH 8
`define PISOS_FIFO_AW 3

`endif

/* File: rtl/pisos_fifo.v */
// Small synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none

module pisos_fifo #(
  parameter WIDTH = 1,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire ref_clk_i,
  input wire srst_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);

  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW-1:0] rd_ptr_next;
  reg [AW:0] count_reg;
  reg [AW:0] count_next;
  reg out_valid_reg;
  reg [WIDTH-1:0] out_data_reg;
  wire push;
  wire pop;

  // Wrapping pointer step
  function [AW-1:0] ptr_step;
    input [AW-1:0] ptr;
    begin
      ptr_step = (ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : ptr + 1'b1;
    end
  endfunction

  // Full from the count; valid and data come from flops
  assign in_ready_o = (count_reg != DEPTH[AW:0]);
  assign out_valid_o = out_valid_reg;
  assign out_data_o = out_data_reg;
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_reg & out_ready_i;

  // =====================================================
  // Next read pointer and word count
  always @*
  begin
    rd_ptr_next = rd_ptr_reg;
    if (pop)
    begin
      rd_ptr_next = ptr_step(rd_ptr_reg);
    end
    count_next = count_reg;
    if (push && !pop)
    begin
      count_next = count_reg + 1'b1;
    end
    else if (pop && !push)
    begin
      count_next = count_reg - 1'b1;
    end
  end

  // =====================================================
  // Storage, unreset
  always @(posedge ref_clk_i)
  begin
    if (push)
    begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  // =====================================================
  // Pointers and count
  always @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
      out_valid_reg <= 1'b0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= ptr_step(wr_ptr_reg);
      end
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
      out_valid_reg <= (count_next != {(AW+1){1'b0}});
    end
  end

  // Head word, bypassed when the write lands on the next read slot
  always @(posedge ref_clk_i)
  begin
    if (push && (rd_ptr_next == wr_ptr_reg))
    begin
      out_data_reg <= in_data_i;
    end
    else
    begin
      out_data_reg <= mem_reg[rd_ptr_next];
    end
  end

endmodule // pisos_fifo

`default_nettype wire

/* File: rtl/pisos_shifter.v */
// Eight-stage parallel-load shift register with serial output stream
`timescale 1ns/1ps
`default_nettype none
`include "pisos_defs.vh"

module pisos_shifter (
  input wire ref_clk_i,
  input wire srst_i,
  input wire [`PISOS_STAGES-1:0] par_data_i,
  input wire serial_in_i,
  input wire shift_not_load_i,
  input wire shift_clk_i,
  input wire clock_inhibit_i,
  output wire serial_out_o,
  output wire serial_out_n_o,
  output wire shift_ready_o,
  output wire drop_valid_o,
  input wire drop_ready_i,
  output wire drop_data_o
);

  reg [`PISOS_STAGES-1:0] stage_reg;
  reg [`PISOS_STAGES-1:0] stage_next;
  reg serial_out_reg;
  reg serial_out_n_reg;
  reg clk_prev_reg;
  reg inh_prev_reg;
  reg ready_reg;
  wire fifo_ready;
  wire shift_event;

  // Rising edge of one source while the other sits low
  function edge_ok;
    input cur;
    input prev;
    input other;
    begin
      edge_ok = cur & ~prev & ~other;
    end
  endfunction

  // =====================================================
  // Edge qualification; live FIFO room also gates, as ready_reg lags a cycle
  assign shift_event = shift_not_load_i & ready_reg & fifo_ready &
    (edge_ok(shift_clk_i, clk_prev_reg, clock_inhibit_i) |
     edge_ok(clock_inhibit_i, inh_prev_reg, shift_clk_i));

  always @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      clk_prev_reg <= 1'b0;
      inh_prev_reg <= 1'b0;
      ready_reg <= 1'b0;
    end
    else
    begin
      clk_prev_reg <= shift_clk_i;
      inh_prev_reg <= clock_inhibit_i;
      ready_reg <= fifo_ready;
    end
  end

  // =====================================================
  // Next stage value: load, shift or hold
  always @*
  begin
    stage_next = stage_reg;
    if (!shift_not_load_i)
    begin
      stage_next = par_data_i;
    end
    else if (shift_event)
    begin
      // Serial in enters stage 0, stage 7 drops out
      stage_next = {stage_reg[`PISOS_LAST-1:0], serial_in_i};
    end
  end

  // Stages carry no reset
  always @(posedge ref_clk_i)
  begin
    stage_reg <= stage_next;
  end

  // Registered true and inverted outputs
  always @(posedge ref_clk_i)
  begin
    serial_out_reg <= stage_next[`PISOS_LAST];
    serial_out_n_reg <= ~stage_next[`PISOS_LAST];
  end

  assign serial_out_o = serial_out_reg;
  assign serial_out_n_o = serial_out_n_reg;
  assign shift_ready_o = ready_reg;

  // =====================================================
  // Bits leaving the chain are streamed out
  pisos_fifo #(
    .WIDTH(`PISOS_FIFO_WIDTH),
    .DEPTH(`PISOS_FIFO_DEPTH),
    .AW(`PISOS_FIFO_AW)
  ) u_fifo (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .in_valid_i(shift_event),
    .in_ready_o(fifo_ready),
    .in_data_i(stage_reg[`PISOS_LAST]),
    .out_valid_o(drop_valid_o),
    .out_ready_i(drop_ready_i),
    .out_data_o(drop_data_o)
  );

endmodule // pisos_shifter

`default_nettype wire

/* File: verification/pisos_chk_assertions.sv */
// Port checks of the shifter
`timescale 1ns/1ps
`default_nettype none
module pisos_chk (
  input wire ref_clk_i,
  input wire srst_i,
  input wire [7:0] par_data_i,
  input wire shift_not_load_i,
  input wire shift_clk_i,
  input wire clock_inhibit_i,
  input wire serial_out_o,
  input wire serial_out_n_o,
  input wire drop_valid_o
);
  reg ck_q, ih_q;
  wire sh = shift_not_load_i, q = serial_out_o, dv = drop_valid_o, p7 = par_data_i[7];
  // Pin edge as the shifter takes it
  wire edg = sh && ((shift_clk_i && !ck_q && !clock_inhibit_i) ||
    (clock_inhibit_i && !ih_q && !shift_clk_i));
  // Pin levels one cycle back
  always @(posedge ref_clk_i) {ck_q, ih_q} <= {shift_clk_i, clock_inhibit_i};
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  AST_LOAD: assert property (!sh |=> q == $past(p7)) else $error("load");
  AST_LOADN: assert property (!sh |=> serial_out_n_o != $past(p7)) else $error("loadn");
  AST_CMPL: assert property (serial_out_n_o != q) else $error("compl");
  AST_HOLD: assert property (sh && !edg |=> $stable(q)) else $error("hold");
  AST_BOTH: assert property (sh && clock_inhibit_i && shift_clk_i |=> $stable(q))
    else $error("inhibit");
  AST_PUSH: assert property (edg |=> dv) else $error("push");
  AST_IDLE: assert property (!edg && !dv |=> !dv) else $error("idle");
  AST_RST: assert property ($fell(srst_i) |-> !dv) else $error("rst");
endmodule // pisos_chk
bind pisos_shifter pisos_chk u_chk (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
  .par_data_i(par_data_i), .shift_not_load_i(shift_not_load_i), .shift_clk_i(shift_clk_i),
  .clock_inhibit_i(clock_inhibit_i), .serial_out_o(serial_out_o),
  .serial_out_n_o(serial_out_n_o), .drop_valid_o(drop_valid_o));
`default_nettype wire

/* File: verification/pisos_sink.sv */
// Drain side of the dropped-bit stream
`timescale 1ns/1ps
`default_nettype none
module pisos_sink (
  input wire logic ref_clk_i,
  input wire logic drop_valid_i,
  input wire logic drop_data_i,
  output logic drop_ready_o = 1'b0,
  output logic take_o = 1'b0,
  output logic take_bit_o = 1'b0
);
  // Ready on every other cycle, changed off the sampling edge
  always @(negedge ref_clk_i) drop_ready_o <= !drop_ready_o;
  // A bit is taken where valid and ready meet at the rising edge
  always @(posedge ref_clk_i)
  begin
    take_o <= drop_valid_i && drop_ready_o;
    take_bit_o <= drop_data_i;
  end
endmodule // pisos_sink
`default_nettype wire

/* File: verification/tb_parallel_in_serial_out_shifter.sv */
// Self-checking bench of the shifter
`timescale 1ns/1ps
`default_nettype none
module tb_parallel_in_serial_out_shifter;
  logic clk = 0, rst = 1, snl = 0, sck = 0, inh = 0, sin = 0, go;
  logic [7:0] par = 8'h00, m, up = 8'h00;
  logic [31:0] s = 32'h000106B9;
  int num_errors = 0, num_checks = 0, cyc = 0;
  bit q[$];
  wire so, son, sr, dv, dd, dr, tk, tkb;
  pisos_shifter dut (.ref_clk_i(clk), .srst_i(rst), .par_data_i(par), .serial_in_i(sin),
    .shift_not_load_i(snl), .shift_clk_i(sck), .clock_inhibit_i(inh), .serial_out_o(so),
    .serial_out_n_o(son), .shift_ready_o(sr), .drop_valid_o(dv), .drop_ready_i(dr),
    .drop_data_o(dd));
  pisos_sink snk (.ref_clk_i(clk), .drop_valid_i(dv), .drop_data_i(dd), .drop_ready_o(dr),
    .take_o(tk), .take_bit_o(tkb));
  // Clock and cycle ceiling
  initial forever #50 clk = ~clk;
  always @(posedge clk) if (++cyc > 2000) summarize();
  // Xorshift step
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction
  // Compare seen with expected
  task chk(input string n, input logic g, input logic e);
    num_checks++;
    if (g !== e) num_errors++;
    if (g !== e) $display("[FAIL] %s exp %b got %b", n, e, g);
  endtask
  // One falling edge; score a bit the sink took at the rising edge before
  task step;
    @(negedge clk);
    if (tk && q.size() == 0) chk("drop_valid_o", 1'b1, 1'b0);
    else if (tk) chk("drop_data_o", tkb, q.pop_front());
  endtask
  task summarize;
    num_errors += int'(cyc > 2000);
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // A load every ninth iteration, else a pulse on one pin, or on both pins where i % 9 == 5
  initial
  begin
    repeat (20) step();
    rst = 0;
    // Serial input comes from a modelled upstream chained shifter
    for (int i = 0; i < 81; i++)
    begin
      {snl, go, sin, par} = {i % 9 != 0, i % 9 != 5, up[7], s[15:8]};
      {sck, inh} = snl ? {!s[1] || !go, s[1] || !go} : 2'h0;
      if (snl && go) q.push_back(m[7]);
      if (snl && go) {m, up} = {m[6:0], sin, up[6:0], s[0]};
      step();
      {sck, inh, par} = {2'h0, s[23:16]};
      if (!snl) {m, up} = {par, s[31:24]};
      step();
      chk("serial_out_o", so, m[7]);
      chk("serial_out_n_o", son, !m[7]);
      chk("shift_ready_o", sr, 1'b1);
      s = xs(s);
    end
    // Drain the dropped-bit stream
    repeat (20) step();
    chk("drop_valid_o", dv, q.size() != 0);
    summarize();
  end
endmodule // tb_parallel_in_serial_out_shifter
`default_nettype wire
